/* File: rtl/iopwm_top.sv */
// Purpose: five 8-bit io ports with direction registers, tone output and 4-channel pwm
// Assumes: cpu reads and writes data memory in single-cycle strobes; pads synchronous
// Notes:   pull-high, tone and pwm selections are build-time parameters
module iopwm_top
  import iopwm_pkg::*;
#(
  parameter logic [NPORT-1:0]      PULL_HIGH = 5'h1F,
  parameter logic                  TONE_EN   = 1'b1,
  parameter iopwm_pkg::iopwm_tone_src_e TONE_SRC = iopwm_pkg::IOPWM_TONE_TMR0,
  parameter logic                  PWM_EN    = 1'b1,
  parameter iopwm_pkg::iopwm_split_e PWM_SPLIT = iopwm_pkg::IOPWM_SPLIT_6_2
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // cpu data-memory access
  input  wire logic [7:0] mem_addr_i,
  input  wire logic       mem_wr_i,
  input  wire logic [7:0] mem_wdata_i,
  input  wire logic       mem_rd_i,
  output logic      [7:0] mem_rdata_o,
  // timer overflow pulses
  input  wire logic       tmr0_ovf_i,
  input  wire logic       tmr1_ovf_i,
  // port a pads
  input  wire logic [7:0] port_a_pad_i,
  output logic      [7:0] port_a_pad_o,
  output logic      [7:0] port_a_pad_oe_o,
  output logic      [7:0] port_a_pull_o,
  // port b pads
  input  wire logic [7:0] port_b_pad_i,
  output logic      [7:0] port_b_pad_o,
  output logic      [7:0] port_b_pad_oe_o,
  output logic      [7:0] port_b_pull_o,
  // port c pads
  input  wire logic [7:0] port_c_pad_i,
  output logic      [7:0] port_c_pad_o,
  output logic      [7:0] port_c_pad_oe_o,
  output logic      [7:0] port_c_pull_o,
  // port d pads
  input  wire logic [7:0] port_d_pad_i,
  output logic      [7:0] port_d_pad_o,
  output logic      [7:0] port_d_pad_oe_o,
  output logic      [7:0] port_d_pull_o,
  // port f pads
  input  wire logic [7:0] port_f_pad_i,
  output logic      [7:0] port_f_pad_o,
  output logic      [7:0] port_f_pad_oe_o,
  output logic      [7:0] port_f_pull_o,
  // shared functions
  output logic            wake_o,
  output logic            ext_int_n_o,
  output logic            tone_o
);
  import iopwm_pkg::*;

  logic [7:0] data_reg  [NPORT];
  logic [7:0] dir_reg   [NPORT];
  logic [7:0] duty_reg  [NPWM];
  logic [7:0] duty_act_reg [NPWM];
  logic [7:0] pad_in    [NPORT];
  logic [7:0] drive     [NPORT];
  logic [7:0] pad_o_reg [NPORT];
  logic [7:0] oe_reg    [NPORT];
  logic [7:0] pull_reg  [NPORT];
  logic [7:0] pwm_cnt_reg;
  logic [NPWM-1:0] pwm_lvl;
  logic       tone_reg;
  logic [7:0] pa_prev_reg;
  logic       wake_armed_reg;
  logic       tone_hit;
  logic [7:0] rd_value;

  function automatic logic [7:0] data_ofs(input int k);
    case (k)
      0:       data_ofs = OFS_PORT_A_DATA;
      1:       data_ofs = OFS_PORT_B_DATA;
      2:       data_ofs = OFS_PORT_C_DATA;
      3:       data_ofs = OFS_PORT_D_DATA;
      default: data_ofs = OFS_PORT_F_DATA;
    endcase
  endfunction

  function automatic logic [7:0] dir_ofs(input int k);
    case (k)
      0:       dir_ofs = OFS_PORT_A_DIR;
      1:       dir_ofs = OFS_PORT_B_DIR;
      2:       dir_ofs = OFS_PORT_C_DIR;
      3:       dir_ofs = OFS_PORT_D_DIR;
      default: dir_ofs = OFS_PORT_F_DIR;
    endcase
  endfunction

  function automatic logic [7:0] duty_ofs(input int k);
    case (k)
      0:       duty_ofs = OFS_DUTY_CH0;
      1:       duty_ofs = OFS_DUTY_CH1;
      2:       duty_ofs = OFS_DUTY_CH2;
      default: duty_ofs = OFS_DUTY_CH3;
    endcase
  endfunction

  // pwm level for one channel at counter position
  function automatic logic pwm_level(input logic [7:0] duty, input logic [7:0] cnt,
                                     input iopwm_split_e split);
    logic [7:0] high_len;
    logic [7:0] pos;
    high_len = 8'h00;
    pos      = 8'h00;
    if (split == IOPWM_SPLIT_6_2) begin
      pos      = {2'b00, cnt[5:0]};
      high_len = {2'b00, duty[7:2]} + ((cnt[7:6] < duty[1:0]) ? 8'h01 : 8'h00);
    end else begin
      pos      = {1'b0, cnt[6:0]};
      high_len = {1'b0, duty[7:1]} + (({1'b0, cnt[7]} < {1'b0, duty[0]}) ? 8'h01 : 8'h00);
    end
    pwm_level = (pos < high_len);
  endfunction

  // pad levels, read straight without latching
  assign pad_in[0] = port_a_pad_i;
  assign pad_in[1] = port_b_pad_i;
  assign pad_in[2] = port_c_pad_i;
  assign pad_in[3] = port_d_pad_i;
  assign pad_in[4] = port_f_pad_i;

  // port output latches, held until the next write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NPORT; k++) begin
        data_reg[k] <= RST_PORT_DATA;
      end
    end else if (mem_wr_i) begin
      for (int k = 0; k < NPORT; k++) begin
        if (mem_addr_i == data_ofs(k)) begin
          data_reg[k] <= mem_wdata_i;
        end
      end
    end
  end

  // direction registers, all lines inputs after reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NPORT; k++) begin
        dir_reg[k] <= RST_PORT_DIR;
      end
    end else if (mem_wr_i) begin
      for (int k = 0; k < NPORT; k++) begin
        if (mem_addr_i == dir_ofs(k)) begin
          dir_reg[k] <= mem_wdata_i;
        end
      end
    end
  end

  // duty registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int j = 0; j < NPWM; j++) begin
        duty_reg[j] <= RST_DUTY;
      end
    end else if (mem_wr_i) begin
      for (int j = 0; j < NPWM; j++) begin
        if (mem_addr_i == duty_ofs(j)) begin
          duty_reg[j] <= mem_wdata_i;
        end
      end
    end
  end

  // pwm period counter, free running over 256 clocks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_cnt_reg <= 8'h00;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // active duty copies, reloaded only at a period boundary
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int j = 0; j < NPWM; j++) begin
        duty_act_reg[j] <= RST_DUTY;
      end
    end else if (pwm_cnt_reg == PWM_PERIOD_LAST) begin
      for (int j = 0; j < NPWM; j++) begin
        duty_act_reg[j] <= duty_reg[j];
      end
    end
  end

  // per-channel pwm level from the active duty
  always_comb begin
    for (int j = 0; j < NPWM; j++) begin
      pwm_lvl[j] = pwm_level(duty_act_reg[j], pwm_cnt_reg, PWM_SPLIT);
    end
  end

  // overflow pulse of the selected timer
  assign tone_hit = (TONE_SRC == IOPWM_TONE_TMR0) ? tmr0_ovf_i : tmr1_ovf_i;

  // tone divider, half the overflow rate
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_reg <= 1'b0;
    end else if (tone_hit) begin
      tone_reg <= ~tone_reg;
    end
  end

  // pin drive values with shared functions
  always_comb begin
    for (int k = 0; k < NPORT; k++) begin
      drive[k] = data_reg[k];
    end
    if (TONE_EN) begin
      drive[PORT_A][TONE_BIT] = data_reg[PORT_A][TONE_BIT] & tone_reg;
    end
    if (PWM_EN) begin
      for (int j = 0; j < NPWM; j++) begin
        drive[PORT_D][j] = data_reg[PORT_D][j] & pwm_lvl[j];
      end
    end
  end

  // registered pad drive values
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NPORT; k++) begin
        pad_o_reg[k] <= RST_PORT_DATA;
      end
    end else begin
      for (int k = 0; k < NPORT; k++) begin
        pad_o_reg[k] <= drive[k];
      end
    end
  end

  // output enables, high where the direction bit is 0
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NPORT; k++) begin
        oe_reg[k] <= 8'h00;
      end
    end else begin
      for (int k = 0; k < NPORT; k++) begin
        oe_reg[k] <= ~dir_reg[k];
      end
    end
  end

  // pull-ups only on input lines of ports with the option
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NPORT; k++) begin
        pull_reg[k] <= 8'h00;
      end
    end else begin
      for (int k = 0; k < NPORT; k++) begin
        pull_reg[k] <= PULL_HIGH[k] ? dir_reg[k] : 8'h00;
      end
    end
  end

  // read mux: pad for inputs, latch for outputs
  always_comb begin
    rd_value = 8'h00;
    for (int k = 0; k < NPORT; k++) begin
      if (mem_addr_i == data_ofs(k)) begin
        rd_value = (dir_reg[k] & pad_in[k]) | (~dir_reg[k] & data_reg[k]);
      end
      if (mem_addr_i == dir_ofs(k)) begin
        rd_value = dir_reg[k];
      end
    end
    for (int j = 0; j < NPWM; j++) begin
      if (mem_addr_i == duty_ofs(j)) begin
        rd_value = duty_reg[j];
      end
    end
  end

  // read data taken on the strobe edge, held until the next read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rdata_o <= RST_RDATA;
    end else if (mem_rd_i) begin
      mem_rdata_o <= rd_value;
    end
  end

  // port a history for change detection
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_prev_reg    <= 8'h00;
      wake_armed_reg <= 1'b0;
    end else begin
      pa_prev_reg    <= port_a_pad_i;
      wake_armed_reg <= 1'b1;
    end
  end

  // wake on any change of a port a input line, only once history is valid
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_armed_reg & (|((port_a_pad_i ^ pa_prev_reg) & dir_reg[PORT_A]));
    end
  end

  // interrupt pin follows a5
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_int_n_o <= 1'b1;
    end else begin
      ext_int_n_o <= port_a_pad_i[INT_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_o <= 1'b0;
    end else begin
      tone_o <= tone_reg;
    end
  end

  // pad drive values
  assign port_a_pad_o    = pad_o_reg[0];
  assign port_b_pad_o    = pad_o_reg[1];
  assign port_c_pad_o    = pad_o_reg[2];
  assign port_d_pad_o    = pad_o_reg[3];
  assign port_f_pad_o    = pad_o_reg[4];

  // output enables
  assign port_a_pad_oe_o = oe_reg[0];
  assign port_b_pad_oe_o = oe_reg[1];
  assign port_c_pad_oe_o = oe_reg[2];
  assign port_d_pad_oe_o = oe_reg[3];
  assign port_f_pad_oe_o = oe_reg[4];

  // pull-up enables
  assign port_a_pull_o   = pull_reg[0];
  assign port_b_pull_o   = pull_reg[1];
  assign port_c_pull_o   = pull_reg[2];
  assign port_d_pull_o   = pull_reg[3];
  assign port_f_pull_o   = pull_reg[4];
endmodule

/* File: pkg/iopwm_pkg.sv */
// Purpose: constants for the io port and pwm block
// Assumes: 8-bit cpu data-memory bus, byte addresses as printed
// Notes:   port index 0..4 stands for ports a, b, c, d, f
package iopwm_pkg;
  localparam int          NPORT           = 5;
  localparam int          PORT_A          = 0;
  localparam int          PORT_D          = 3;
  localparam logic [7:0]  OFS_PORT_A_DATA = 8'h12;
  localparam logic [7:0]  OFS_PORT_A_DIR  = 8'h13;
  localparam logic [7:0]  OFS_PORT_B_DATA = 8'h14;
  localparam logic [7:0]  OFS_PORT_B_DIR  = 8'h15;
  localparam logic [7:0]  OFS_PORT_C_DATA = 8'h16;
  localparam logic [7:0]  OFS_PORT_C_DIR  = 8'h17;
  localparam logic [7:0]  OFS_PORT_D_DATA = 8'h18;
  localparam logic [7:0]  OFS_PORT_D_DIR  = 8'h19;
  localparam logic [7:0]  OFS_DUTY_CH0    = 8'h1A;
  localparam logic [7:0]  OFS_DUTY_CH1    = 8'h1B;
  localparam logic [7:0]  OFS_DUTY_CH2    = 8'h1C;
  localparam logic [7:0]  OFS_DUTY_CH3    = 8'h1D;
  localparam logic [7:0]  OFS_PORT_F_DATA = 8'h28;
  localparam logic [7:0]  OFS_PORT_F_DIR  = 8'h29;
  localparam logic [7:0]  RST_PORT_DATA   = 8'hFF;
  localparam logic [7:0]  RST_PORT_DIR    = 8'hFF;
  localparam logic [7:0]  RST_DUTY        = 8'h00;
  localparam logic [7:0]  RST_RDATA       = 8'h00;
  localparam int          TONE_BIT        = 3;
  localparam int          INT_BIT         = 5;
  localparam int          NPWM            = 4;
  localparam logic [7:0]  PWM_PERIOD_LAST = 8'hFF;
  typedef enum logic [0:0] {
    IOPWM_SPLIT_6_2 = 1'b0,
    IOPWM_SPLIT_7_1 = 1'b1
  } iopwm_split_e;
  typedef enum logic [0:0] {
    IOPWM_TONE_TMR0 = 1'b0,
    IOPWM_TONE_TMR1 = 1'b1
  } iopwm_tone_src_e;
endpackage

/* File: bench/iopwm_pad_model.sv */
// Purpose: pad ring seen from outside the five io ports
// Assumes: pads settle within the cycle
// Notes:   a released line without pull-up shows the inverse of its last level
module iopwm_pad_model (
  // clock
  input  wire logic        clock_i,
  // design side
  input  wire logic [39:0] drive_i,
  input  wire logic [39:0] oe_i,
  input  wire logic [39:0] pull_i,
  // outside source
  input  wire logic [39:0] ext_i,
  input  wire logic [39:0] ext_en_i,
  // resolved levels
  output logic      [39:0] pads_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [39:0] last_reg;
  always_ff @(posedge clock_i) begin
    last_reg <= pads_o;
  end
  // push-pull drive wins, then outside source, then pull-up
  assign pads_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pull_i | ~last_reg));
endmodule

/* File: bench/iopwm_properties.sv */
// Purpose: port-level checks of the io port and pwm block
// Assumes: default tone source and build options
// Notes:   bound to the top module below
module iopwm_properties
  import iopwm_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic       mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic       mem_rd_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic       tmr0_ovf_i,
  input wire logic [7:0] port_a_pad_i,
  input wire logic [7:0] port_a_pad_o,
  input wire logic [7:0] port_a_pad_oe_o,
  input wire logic [7:0] port_a_pull_o,
  input wire logic [7:0] port_b_pad_oe_o,
  input wire logic [7:0] port_c_pad_i,
  input wire logic [7:0] port_c_pad_oe_o,
  input wire logic [7:0] port_c_pull_o,
  input wire logic       wake_o,
  input wire logic       ext_int_n_o,
  input wire logic       tone_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  reset_inputs_a: assert property ($rose(rst_n_i) |->
    (port_a_pad_oe_o | port_b_pad_oe_o | port_c_pad_oe_o) == 8'h00)
    else $error("lines not inputs after reset");
  dir_drives_a: assert property (mem_wr_i && mem_addr_i == OFS_PORT_B_DIR |=>
    ##1 port_b_pad_oe_o == ~$past(mem_wdata_i, 2))
    else $error("output enable does not follow direction");
  input_read_a: assert property (mem_rd_i && mem_addr_i == OFS_PORT_C_DATA && port_c_pad_oe_o == 8'h00
    |=> mem_rdata_o == $past(port_c_pad_i))
    else $error("input read not the live pad");
  pull_inputs_a: assert property (
    ((port_a_pull_o & port_a_pad_oe_o) | (port_c_pull_o & port_c_pad_oe_o)) == 8'h00)
    else $error("pull-up on an output line");
  ext_int_copy_a: assert property ($past(rst_n_i) |-> ext_int_n_o == $past(port_a_pad_i[INT_BIT]))
    else $error("interrupt line not the pad");
  tone_toggle_a: assert property ($past(rst_n_i, 2) |-> tone_o == ($past(tone_o) ^ $past(tmr0_ovf_i, 2)))
    else $error("tone did not toggle on overflow");
  tone_gate_a: assert property ($past(rst_n_i) && port_a_pad_oe_o[TONE_BIT] && port_a_pad_o[TONE_BIT] |-> tone_o)
    else $error("tone pin high while tone low");
  wake_cause_a: assert property ($past(rst_n_i, 3) && wake_o |->
    $past(port_a_pad_i) != $past(port_a_pad_i, 2) || $past(port_a_pad_i, 2) != $past(port_a_pad_i, 3))
    else $error("wake without a pad change");
endmodule
bind iopwm_top iopwm_properties u_props (.clock_i, .rst_n_i, .mem_addr_i, .mem_wr_i, .mem_wdata_i, .mem_rd_i,
  .mem_rdata_o, .tmr0_ovf_i, .port_a_pad_i, .port_a_pad_o, .port_a_pad_oe_o, .port_a_pull_o, .port_b_pad_oe_o,
  .port_c_pad_i, .port_c_pad_oe_o, .port_c_pull_o, .wake_o, .ext_int_n_o, .tone_o);

/* File: bench/iopwm_tb_top.sv */
// Purpose: self-checking bench for the io port and pwm block
// Assumes: default build options, pwm split 6+2, tone from timer 0
// Notes:   random values from an xorshift seeded with 52
module iopwm_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import iopwm_pkg::*;
  logic clock_i = 1'b0, rst_n_i = 1'b0, mem_wr_i = 1'b0, mem_rd_i = 1'b0, tmr0_ovf_i = 1'b0, tmr1_ovf_i = 1'b0;
  logic [7:0] mem_addr_i = 8'h00, mem_wdata_i = 8'h00, mem_rdata_o, v, d, n, rise;
  logic [7:0] port_a_pad_o, port_a_pad_oe_o, port_a_pull_o, port_b_pad_o, port_b_pad_oe_o, port_b_pull_o;
  logic [7:0] port_c_pad_o, port_c_pad_oe_o, port_c_pull_o, port_d_pad_o, port_d_pad_oe_o, port_d_pull_o;
  logic [7:0] port_f_pad_o, port_f_pad_oe_o, port_f_pull_o, duty [4];
  wire logic [7:0] port_a_pad_i, port_b_pad_i, port_c_pad_i, port_d_pad_i, port_f_pad_i;
  logic wake_o, ext_int_n_o, tone_o, t = 1'b0;
  logic [39:0] ext = 40'h0, ext_en = {40{1'b1}};
  logic [8:0] hi [4];
  logic [8:0] hi_71 [4];
  logic [7:0] port_d_pad_o_71, rise_71;
  logic [31:0] seed = 32'd52;
  logic [7:0] dirs [5] = '{OFS_PORT_A_DIR, OFS_PORT_B_DIR, OFS_PORT_C_DIR, OFS_PORT_D_DIR, OFS_PORT_F_DIR};
  logic [7:0] corner [4] = '{8'h00, 8'hFF, 8'h81, 8'h43};
  int bad_count = 0, n_compared = 0;
  iopwm_top u_dut (.clock_i, .rst_n_i, .mem_addr_i, .mem_wr_i, .mem_wdata_i, .mem_rd_i, .mem_rdata_o, .tmr0_ovf_i,
    .tmr1_ovf_i, .port_a_pad_i, .port_a_pad_o, .port_a_pad_oe_o, .port_a_pull_o, .port_b_pad_i, .port_b_pad_o,
    .port_b_pad_oe_o, .port_b_pull_o, .port_c_pad_i, .port_c_pad_o, .port_c_pad_oe_o, .port_c_pull_o, .port_d_pad_i,
    .port_d_pad_o, .port_d_pad_oe_o, .port_d_pull_o, .port_f_pad_i, .port_f_pad_o, .port_f_pad_oe_o, .port_f_pull_o,
    .wake_o, .ext_int_n_o, .tone_o);
  // second build with the 7+1 split, sharing bus and pads
  iopwm_top #(.PWM_SPLIT(IOPWM_SPLIT_7_1)) u_dut_71 (.clock_i, .rst_n_i, .mem_addr_i, .mem_wr_i, .mem_wdata_i,
    .mem_rd_i, .mem_rdata_o(), .tmr0_ovf_i, .tmr1_ovf_i, .port_a_pad_i, .port_a_pad_o(), .port_a_pad_oe_o(),
    .port_a_pull_o(), .port_b_pad_i, .port_b_pad_o(), .port_b_pad_oe_o(), .port_b_pull_o(), .port_c_pad_i,
    .port_c_pad_o(), .port_c_pad_oe_o(), .port_c_pull_o(), .port_d_pad_i, .port_d_pad_o(port_d_pad_o_71),
    .port_d_pad_oe_o(), .port_d_pull_o(), .port_f_pad_i, .port_f_pad_o(), .port_f_pad_oe_o(), .port_f_pull_o(),
    .wake_o(), .ext_int_n_o(), .tone_o());
  iopwm_pad_model u_pads (.clock_i, .ext_i(ext), .ext_en_i(ext_en),
    .drive_i({port_f_pad_o, port_d_pad_o, port_c_pad_o, port_b_pad_o, port_a_pad_o}),
    .oe_i({port_f_pad_oe_o, port_d_pad_oe_o, port_c_pad_oe_o, port_b_pad_oe_o, port_a_pad_oe_o}),
    .pull_i({port_f_pull_o, port_d_pull_o, port_c_pull_o, port_b_pull_o, port_a_pull_o}),
    .pads_o({port_f_pad_i, port_d_pad_i, port_c_pad_i, port_b_pad_i, port_a_pad_i}));
  always #12.5 clock_i = ~clock_i;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // read value: pad for input bits, latch for output bits
  function automatic logic [7:0] mix(input logic [7:0] dir, lat, pad);
    return (pad & dir) | (lat & ~dir);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #2;
  endtask
  // strobe for one edge, then one idle cycle
  task automatic wr(input logic [7:0] a, dat);
    mem_addr_i = a;
    mem_wdata_i = dat;
    mem_wr_i = 1'b1;
    tick(1);
    mem_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    mem_addr_i = a;
    mem_rd_i = 1'b1;
    tick(1);
    dat = mem_rdata_o;
    mem_rd_i = 1'b0;
    tick(1);
  endtask
  task automatic ovf(input logic sel);
    tmr0_ovf_i = ~sel;
    tmr1_ovf_i = sel;
    tick(1);
    {tmr0_ovf_i, tmr1_ovf_i} = 2'b00;
    tick(3);
  endtask
  task automatic count_pwm();
    logic p, q;
    p = port_d_pad_o[2];
    q = port_d_pad_o_71[2];
    rise = 8'h00;
    rise_71 = 8'h00;
    foreach (hi[j]) hi[j] = 9'h000;
    foreach (hi_71[j]) hi_71[j] = 9'h000;
    repeat (256) begin
      tick(1);
      foreach (hi[j]) hi[j] += port_d_pad_o[j];
      foreach (hi_71[j]) hi_71[j] += port_d_pad_o_71[j];
      rise += {7'h00, port_d_pad_o[2] & ~p};
      rise_71 += {7'h00, port_d_pad_o_71[2] & ~q};
      p = port_d_pad_o[2];
      q = port_d_pad_o_71[2];
    end
  endtask
  task automatic test_done();
    $display("compared %0d wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1ms;
    bad_count++;
    test_done();
  end
  initial begin
    tick(12);
    rst_n_i = 1'b1;
    check("oe", port_a_pad_oe_o | port_b_pad_oe_o | port_d_pad_oe_o | port_f_pad_oe_o, 8'h00);
    foreach (dirs[i]) begin
      rd(dirs[i], v);
      check("direction", v, 8'hFF);
    end
    rd(8'h00, v);
    check("unmapped", v, 8'h00);
    wr(OFS_PORT_B_DIR, 8'hF0);
    for (int i = 0; i < 8; i++) begin
      ext = {rnd(), rnd(), rnd(), rnd(), rnd()};
      d = rnd();
      wr(OFS_PORT_B_DATA, d);
      rd(OFS_PORT_C_DATA, v);
      check("port c", v, ext[23:16]);
      rd(OFS_PORT_F_DATA, v);
      check("port f", v, ext[39:32]);
      rd(OFS_PORT_B_DATA, v);
      check("port b", v, mix(8'hF0, d, ext[15:8]));
      check("b pads", port_b_pad_o & 8'h0F, d & 8'h0F);
    end
    tick(20);
    check("b held", port_b_pad_o & 8'h0F, d & 8'h0F);
    wr(OFS_PORT_B_DATA, v | 8'h02);
    check("b bit set", port_b_pad_o & 8'h0F, (d | 8'h02) & 8'h0F);
    ext_en[7:0] = 8'h00;
    rd(OFS_PORT_A_DATA, v);
    check("pull-high", v, 8'hFF);
    ext_en[7:0] = 8'hFF;
    tick(4);
    ext[5] = ~ext[5];
    n = 8'h00;
    repeat (4) begin
      tick(1);
      n += {7'h00, wake_o};
    end
    check("wake", n, 8'h01);
    check("int line", {7'h00, ext_int_n_o}, {7'h00, ext[5]});
    wr(OFS_PORT_A_DIR, 8'h00);
    wr(OFS_PORT_A_DATA, 8'h08);
    for (int i = 0; i < 4; i++) begin
      t = t ^ ~i[0];
      ovf(i[0]);
      check("tone pin", {7'h00, port_a_pad_o[3]}, {7'h00, t});
      check("tone out", {7'h00, tone_o}, {7'h00, t});
    end
    wr(OFS_PORT_A_DATA, 8'h00);
    ovf(1'b0);
    check("tone off", {7'h00, port_a_pad_o[3]}, 8'h00);
    wr(OFS_PORT_D_DIR, 8'h00);
    wr(OFS_PORT_D_DATA, 8'h0F);
    for (int r = 0; r < 3; r++) begin
      foreach (duty[j]) begin
        duty[j] = (r == 0) ? corner[j] : rnd();
        wr(OFS_DUTY_CH0 + 8'(j), duty[j]);
        rd(OFS_DUTY_CH0 + 8'(j), v);
        check("duty", v, duty[j]);
      end
      tick(300);
      count_pwm();
      foreach (duty[j]) check("pwm high", hi[j][7:0], duty[j]);
      foreach (duty[j]) check("pwm high 7+1", hi_71[j][7:0], duty[j]);
      if (r == 0) check("pwm pulses", rise, 8'h04);
      if (r == 0) check("pwm pulses 7+1", rise_71, 8'h02);
    end
    wr(OFS_PORT_D_DATA, 8'h0E);
    tick(2);
    count_pwm();
    check("pwm gated", hi[0][7:0], 8'h00);
    check("pwm open", hi[1][7:0], duty[1]);
    check("pwm gated 7+1", hi_71[0][7:0], 8'h00);
    rst_n_i = 1'b0;
    tick(2);
    check("oe in reset", port_a_pad_oe_o | port_d_pad_oe_o, 8'h00);
    rst_n_i = 1'b1;
    n = 8'h00;
    repeat (3) begin
      tick(1);
      n += {7'h00, wake_o};
    end
    check("no wake after reset", n, 8'h00);
    rd(OFS_PORT_A_DIR, v);
    check("dir after reset", v, 8'hFF);
    test_done();
  end
endmodule
